// ---- verilog/intc_pkg.sv ----
// constants shared by the interrupt controller files
`default_nettype none
package intc_pkg;

  // ----------------------------------------------------------------
  // source numbering and count
  // ----------------------------------------------------------------
  localparam int NUM_SRC   = 15;
  localparam int NUM_EXT   = 8;
  localparam int SRC_EXT_A = 0;
  localparam int SRC_TMR_A = 1;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_TMR_B = 3;
  localparam int SRC_SER   = 4;
  localparam int SRC_TMR_C = 5;
  localparam int SRC_PFAIL = 6;
  localparam int SRC_XBASE = 7;

  // ----------------------------------------------------------------
  // vector layout
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam int         VEC_STEP = 8;
  // one unused slot sits between the power-fail and extended vectors
  localparam int         VEC_GAP  = 1;

  // ----------------------------------------------------------------
  // special-register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CTRL   = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h88;
  localparam logic [7:0] ADDR_EXT_FLAGS    = 8'h91;
  localparam logic [7:0] ADDR_PFAIL_CTRL   = 8'h93;
  localparam logic [7:0] ADDR_SERIAL_CTRL  = 8'h98;
  localparam logic [7:0] ADDR_STD_ENABLE   = 8'hA8;
  localparam logic [7:0] ADDR_STD_PRIO     = 8'hA9;
  localparam logic [7:0] ADDR_TIMER_C_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_EXT_ENABLE   = 8'hE8;
  localparam logic [7:0] ADDR_EXT_PRIO     = 8'hE9;
  localparam logic [7:0] ADDR_EXT_TRIG     = 8'hEA;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_IDLE       = 0;
  localparam int POS_PIN_A_TRIG = 0;
  localparam int POS_PIN_A_PEND = 1;
  localparam int POS_PIN_B_TRIG = 2;
  localparam int POS_PIN_B_PEND = 3;
  localparam int POS_TMR_A_OVF  = 5;
  localparam int POS_TMR_B_OVF  = 7;
  localparam int POS_SER_RX     = 0;
  localparam int POS_SER_TX     = 1;
  localparam int POS_TMR_C_EXT  = 6;
  localparam int POS_TMR_C_OVF  = 7;
  localparam int POS_PFAIL_FLAG = 4;
  localparam int POS_PFAIL_EN   = 5;
  localparam int POS_GLOBAL_EN  = 7;

  // implemented bits of the partly owned registers
  localparam logic [7:0] MASK_TIMER_CTRL   = 8'hAF;
  localparam logic [7:0] MASK_SERIAL_CTRL  = 8'h03;
  localparam logic [7:0] MASK_TIMER_C_CTRL = 8'hC0;
  localparam logic [7:0] MASK_PFAIL_CTRL   = 8'h30;
  localparam logic [7:0] MASK_STD_ENABLE   = 8'hBF;

  // extended lines 3,5,7,9 (bits 1,3,5,7) are active low
  localparam logic [7:0] EXT_LOW_ACTIVE = 8'hAA;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_STD_PRIO  = 8'h80;
  localparam logic [7:0] RST_EXT_FLAGS = 8'h08;
  localparam logic [7:0] RST_EXT_EN    = 8'hF0;
  localparam logic [7:0] RST_EXT_PRIO  = 8'hF0;
  localparam logic [7:0] RST_EXT_TRIG  = 8'hFF;

  // ----------------------------------------------------------------
  // service nesting
  // ----------------------------------------------------------------
  typedef enum {SVC_NONE, SVC_LOW, SVC_HIGH, SVC_HIGH_OVER_LOW} svc_state_t;

endpackage
`default_nettype wire

// ---- verilog/arrival_arbiter.sv ----
// picks the oldest of several pending requests, ties go to the lower index
`default_nettype none
module arrival_arbiter
  import intc_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] pend,
  input  wire logic [N-1:0] cand,
  output logic              win_valid,
  output logic [3:0]        win_idx
);

  // older_q[i][j] set: request i arrived before request j
  logic [N-1:0][N-1:0] older_q;
  logic [N-1:0][N-1:0] older_d;
  logic [N-1:0]        pend_prev_q;
  logic [N-1:0]        pend_prev_d;
  logic [N-1:0]        arrive;
  logic                beaten;

  always_comb begin
    arrive      = pend & ~pend_prev_q;
    pend_prev_d = pend;
    older_d     = older_q;
    for (int i = 0; i < N; i++) begin
      for (int j = 0; j < N; j++) begin
        if (arrive[i] && arrive[j]) begin
          older_d[i][j] = (i < j);
        end else if (arrive[i]) begin
          older_d[i][j] = 1'b0;
          older_d[j][i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    beaten    = 1'b0;
    // judge on this cycle's order: a request that only just arrived
    // must not win over an older one on stale history
    for (int i = N - 1; i >= 0; i--) begin
      beaten = 1'b0;
      for (int j = 0; j < N; j++) begin
        if (j != i && cand[j] && older_d[j][i]) begin
          beaten = 1'b1;
        end
      end
      if (cand[i] && !beaten) begin
        win_valid = 1'b1;
        win_idx   = 4'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      older_q     <= '0;
      pend_prev_q <= '0;
    end else if (ce) begin
      older_q     <= older_d;
      pend_prev_q <= pend_prev_d;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/mcu_interrupt_controller.sv ----
// two-level interrupt controller with flags, vectors and idle wake-up
//
// Functional notes
// - fifteen sources; software-set flag raises interrupt
// - fixed vector per source, gap before extended
// - running routine only preempted by higher level
// - per-source priority bit, high or low
// - same-level requests served in arrival order
// - same or lower level never nests
// - two active-low pins, own trigger select
// - select 0: low sample sets pending
// - select 1: high then low sets pending
// - lines 2,4,6,8 high; 3,5,7,9 low active
// - trigger-mode bit n: line n+2 edge/level
// - extended lines fixed to peripherals, mode only
// - timers, serial, power-fail are standard sources
// - pin and timer A/B flags auto-clear
// - idle entered at instruction end, output asserted
// - enabled interrupt clears idle, resumes
// - global enable masks all but power-fail
`default_nettype none
module mcu_interrupt_controller
  import intc_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  input  wire logic       CLK_EN,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WE,
  input  wire logic       SFR_RE,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       EXT_REQUEST_PIN_A,
  input  wire logic       EXT_REQUEST_PIN_B,
  input  wire logic       SPI_REQUEST_LINE,
  input  wire logic       TWOWIRE_REQUEST_LINE,
  input  wire logic       USB_REQUEST_LINE,
  input  wire logic       RADIO_REQUEST_LINE,
  input  wire logic       SPARE_REQUEST_LINE,
  input  wire logic       PWM_REQUEST_LINE,
  input  wire logic       ADC_REQUEST_LINE,
  input  wire logic       CIPHER_REQUEST_LINE,
  input  wire logic       TIMER_A_OVERFLOW,
  input  wire logic       TIMER_B_OVERFLOW,
  input  wire logic       TIMER_C_OVERFLOW,
  input  wire logic       TIMER_C_EXTERNAL,
  input  wire logic       SERIAL_TRANSMIT_DONE,
  input  wire logic       SERIAL_RECEIVE_DONE,
  input  wire logic       LOW_BATTERY,
  input  wire logic       INSTR_DONE,
  input  wire logic       IRQ_ACK,
  input  wire logic       IRQ_RETURN,
  output logic            IRQ_REQ,
  output logic      [7:0] IRQ_VECTOR,
  output logic            IRQ_LEVEL,
  output logic            IDLE_MODE_N
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] vector_of(input logic [3:0] idx);
    int slot;
    slot = (int'(idx) >= SRC_XBASE) ? int'(idx) + VEC_GAP : int'(idx);
    return VEC_BASE + 8'(slot * VEC_STEP);
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr);
    return SFR_WE && (SFR_ADDR == addr);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] tctl_q, tctl_d;
  logic [7:0] sctl_q, sctl_d;
  logic [7:0] t2ctl_q, t2ctl_d;
  logic [7:0] pfctl_q, pfctl_d;
  logic [7:0] xflag_q, xflag_d;
  logic [7:0] stden_q, stden_d;
  logic [7:0] stdpr_q, stdpr_d;
  logic [7:0] xen_q, xen_d;
  logic [7:0] xpr_q, xpr_d;
  logic [7:0] extended_trigger_mode_q, extended_trigger_mode_d;
  logic       idle_bit_q, idle_bit_d;
  logic       idle_act_q, idle_act_d;
  logic       pin_a_prev_q, pin_b_prev_q;
  logic [7:0] xline_prev_q;
  logic [7:0] rdata_d;
  logic       req_q, req_d;
  logic [7:0] vec_q, vec_d;
  logic [3:0] src_q, src_d;
  logic       lvl_q, lvl_d;
  svc_state_t svc_q, svc_d;

  logic [7:0]         xline;
  logic [7:0]         xset;
  logic               pin_a_set, pin_b_set;
  logic               take;
  logic [NUM_SRC-1:0] pend, enab, prio, act, cand;
  logic               win_valid;
  logic [3:0]         win_idx;

  // ----------------------------------------------------------------
  // request detection
  // ----------------------------------------------------------------
  always_comb begin
    xline = {CIPHER_REQUEST_LINE, ADC_REQUEST_LINE, PWM_REQUEST_LINE, SPARE_REQUEST_LINE,
             RADIO_REQUEST_LINE, USB_REQUEST_LINE, TWOWIRE_REQUEST_LINE,
             SPI_REQUEST_LINE} ^ EXT_LOW_ACTIVE;
    // edge mode wants an inactive sample right before the active one
    xset = (extended_trigger_mode_q & xline & ~xline_prev_q)
         | (~extended_trigger_mode_q & xline);
    pin_a_set = tctl_q[POS_PIN_A_TRIG] ? (pin_a_prev_q & ~EXT_REQUEST_PIN_A)
                                       : ~EXT_REQUEST_PIN_A;
    pin_b_set = tctl_q[POS_PIN_B_TRIG] ? (pin_b_prev_q & ~EXT_REQUEST_PIN_B)
                                       : ~EXT_REQUEST_PIN_B;
  end

  assign take = IRQ_ACK && req_q;

  // ----------------------------------------------------------------
  // flag and control registers
  // ----------------------------------------------------------------
  // order inside each flag: software write, then hardware clear, then
  // hardware set, so an event in the clearing cycle is kept
  always_comb begin
    tctl_d  = wr_hit(ADDR_TIMER_CTRL) ? (SFR_WDATA & MASK_TIMER_CTRL) : tctl_q;
    sctl_d  = wr_hit(ADDR_SERIAL_CTRL) ? (SFR_WDATA & MASK_SERIAL_CTRL) : sctl_q;
    t2ctl_d = wr_hit(ADDR_TIMER_C_CTRL) ? (SFR_WDATA & MASK_TIMER_C_CTRL) : t2ctl_q;
    pfctl_d = wr_hit(ADDR_PFAIL_CTRL) ? (SFR_WDATA & MASK_PFAIL_CTRL) : pfctl_q;
    xflag_d = wr_hit(ADDR_EXT_FLAGS) ? SFR_WDATA : xflag_q;
    stden_d = wr_hit(ADDR_STD_ENABLE) ? (SFR_WDATA & MASK_STD_ENABLE) : stden_q;
    stdpr_d = wr_hit(ADDR_STD_PRIO) ? SFR_WDATA : stdpr_q;
    xen_d   = wr_hit(ADDR_EXT_ENABLE) ? SFR_WDATA : xen_q;
    xpr_d   = wr_hit(ADDR_EXT_PRIO) ? SFR_WDATA : xpr_q;
    extended_trigger_mode_d = wr_hit(ADDR_EXT_TRIG) ? SFR_WDATA
                                                    : extended_trigger_mode_q;
    if (take) begin
      case (int'(src_q))
        SRC_EXT_A: tctl_d[POS_PIN_A_PEND] = 1'b0;
        SRC_TMR_A: tctl_d[POS_TMR_A_OVF]  = 1'b0;
        SRC_EXT_B: tctl_d[POS_PIN_B_PEND] = 1'b0;
        SRC_TMR_B: tctl_d[POS_TMR_B_OVF]  = 1'b0;
        default: ;
      endcase
    end
    tctl_d[POS_PIN_A_PEND]  = tctl_d[POS_PIN_A_PEND] | pin_a_set;
    tctl_d[POS_PIN_B_PEND]  = tctl_d[POS_PIN_B_PEND] | pin_b_set;
    tctl_d[POS_TMR_A_OVF]   = tctl_d[POS_TMR_A_OVF] | TIMER_A_OVERFLOW;
    tctl_d[POS_TMR_B_OVF]   = tctl_d[POS_TMR_B_OVF] | TIMER_B_OVERFLOW;
    sctl_d[POS_SER_RX]      = sctl_d[POS_SER_RX] | SERIAL_RECEIVE_DONE;
    sctl_d[POS_SER_TX]      = sctl_d[POS_SER_TX] | SERIAL_TRANSMIT_DONE;
    t2ctl_d[POS_TMR_C_OVF]  = t2ctl_d[POS_TMR_C_OVF] | TIMER_C_OVERFLOW;
    t2ctl_d[POS_TMR_C_EXT]  = t2ctl_d[POS_TMR_C_EXT] | TIMER_C_EXTERNAL;
    pfctl_d[POS_PFAIL_FLAG] = pfctl_d[POS_PFAIL_FLAG] | LOW_BATTERY;
    xflag_d                 = xflag_d | xset;
  end

  // ----------------------------------------------------------------
  // source table
  // ----------------------------------------------------------------
  always_comb begin
    pend = {xflag_q,
            pfctl_q[POS_PFAIL_FLAG],
            t2ctl_q[POS_TMR_C_OVF] | t2ctl_q[POS_TMR_C_EXT],
            sctl_q[POS_SER_RX] | sctl_q[POS_SER_TX],
            tctl_q[POS_TMR_B_OVF],
            tctl_q[POS_PIN_B_PEND],
            tctl_q[POS_TMR_A_OVF],
            tctl_q[POS_PIN_A_PEND]};
    enab = {xen_q, pfctl_q[POS_PFAIL_EN], stden_q[SRC_PFAIL-1:0]};
    enab[NUM_SRC-1:0] = enab & {{(NUM_SRC-SRC_PFAIL-1){stden_q[POS_GLOBAL_EN]}}, 1'b1,
                                {SRC_PFAIL{stden_q[POS_GLOBAL_EN]}}};
    prio = {xpr_q, stdpr_q[SRC_PFAIL:0]};
    act  = pend & enab;
  end

  // ----------------------------------------------------------------
  // nesting and arbitration
  // ----------------------------------------------------------------
  // high level wins over low; within a level, oldest arrival first
  always_comb begin
    cand = '0;
    case (svc_q)
      SVC_NONE: cand = (|(act & prio)) ? (act & prio) : (act & ~prio);
      SVC_LOW:  cand = act & prio;
      SVC_HIGH, SVC_HIGH_OVER_LOW: cand = '0;
      default:  cand = '0;
    endcase
  end

  arrival_arbiter #(
    .N (NUM_SRC)
  ) u_arbiter (
    .clk       (CORE_CLK),
    .rst_n     (rst_n),
    .ce        (CLK_EN),
    .pend      (act),
    .cand      (cand),
    .win_valid (win_valid),
    .win_idx   (win_idx)
  );

  always_comb begin
    // drop the request for one cycle after acceptance so a stale
    // vector is not offered twice while the flag is cleared
    req_d = win_valid && !take;
    vec_d = vector_of(win_idx);
    src_d = win_idx;
    lvl_d = prio[win_idx];
    svc_d = svc_q;
    if (take) begin
      case (svc_q)
        SVC_NONE: svc_d = lvl_q ? SVC_HIGH : SVC_LOW;
        SVC_LOW:  svc_d = SVC_HIGH_OVER_LOW;
        default:  svc_d = svc_q;
      endcase
    end else if (IRQ_RETURN) begin
      case (svc_q)
        SVC_HIGH_OVER_LOW: svc_d = SVC_LOW;
        SVC_HIGH, SVC_LOW: svc_d = SVC_NONE;
        default:           svc_d = SVC_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // idle
  // ----------------------------------------------------------------
  always_comb begin
    idle_bit_d = wr_hit(ADDR_POWER_CTRL) ? SFR_WDATA[POS_IDLE] : idle_bit_q;
    idle_act_d = idle_act_q | (idle_bit_q && INSTR_DONE);
    if (|act) begin
      idle_bit_d = 1'b0;
      idle_act_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    case (SFR_ADDR)
      ADDR_POWER_CTRL:   rdata_d = {7'h00, idle_bit_q};
      ADDR_TIMER_CTRL:   rdata_d = tctl_q;
      ADDR_EXT_FLAGS:    rdata_d = xflag_q;
      ADDR_PFAIL_CTRL:   rdata_d = pfctl_q;
      ADDR_SERIAL_CTRL:  rdata_d = sctl_q;
      ADDR_STD_ENABLE:   rdata_d = stden_q;
      ADDR_STD_PRIO:     rdata_d = stdpr_q;
      ADDR_TIMER_C_CTRL: rdata_d = t2ctl_q;
      ADDR_EXT_ENABLE:   rdata_d = xen_q;
      ADDR_EXT_PRIO:     rdata_d = xpr_q;
      ADDR_EXT_TRIG:     rdata_d = extended_trigger_mode_q;
      default:           rdata_d = RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tctl_q                  <= RST_ZERO;
      sctl_q                  <= RST_ZERO;
      t2ctl_q                 <= RST_ZERO;
      pfctl_q                 <= RST_ZERO;
      xflag_q                 <= RST_EXT_FLAGS;
      stden_q                 <= RST_ZERO;
      stdpr_q                 <= RST_STD_PRIO;
      xen_q                   <= RST_EXT_EN;
      xpr_q                   <= RST_EXT_PRIO;
      extended_trigger_mode_q <= RST_EXT_TRIG;
      idle_bit_q              <= 1'b0;
      idle_act_q              <= 1'b0;
      pin_a_prev_q            <= 1'b1;
      pin_b_prev_q            <= 1'b1;
      xline_prev_q            <= RST_ZERO;
      SFR_RDATA               <= RST_ZERO;
      req_q                   <= 1'b0;
      vec_q                   <= RST_ZERO;
      src_q                   <= 4'h0;
      lvl_q                   <= 1'b0;
      svc_q                   <= SVC_NONE;
    end else if (CLK_EN) begin
      tctl_q                  <= tctl_d;
      sctl_q                  <= sctl_d;
      t2ctl_q                 <= t2ctl_d;
      pfctl_q                 <= pfctl_d;
      xflag_q                 <= xflag_d;
      stden_q                 <= stden_d;
      stdpr_q                 <= stdpr_d;
      xen_q                   <= xen_d;
      xpr_q                   <= xpr_d;
      extended_trigger_mode_q <= extended_trigger_mode_d;
      idle_bit_q              <= idle_bit_d;
      idle_act_q              <= idle_act_d;
      pin_a_prev_q            <= EXT_REQUEST_PIN_A;
      pin_b_prev_q            <= EXT_REQUEST_PIN_B;
      xline_prev_q            <= xline;
      if (SFR_RE) begin
        SFR_RDATA <= rdata_d;
      end
      req_q                   <= req_d;
      vec_q                   <= vec_d;
      src_q                   <= src_d;
      lvl_q                   <= lvl_d;
      svc_q                   <= svc_d;
    end
  end

  assign IRQ_REQ     = req_q;
  assign IRQ_VECTOR  = vec_q;
  assign IRQ_LEVEL   = lvl_q;
  assign IDLE_MODE_N = ~idle_act_q;

endmodule
`default_nettype wire

// ---- verification/intc_checker_asserts.sv ----
// port assertions for the interrupt controller
`default_nettype none
module intc_checker (
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       CLK_EN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WE,
  input wire logic       SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       INSTR_DONE,
  input wire logic       IRQ_ACK,
  input wire logic       IRQ_RETURN,
  input wire logic       IRQ_REQ,
  input wire logic [7:0] IRQ_VECTOR,
  input wire logic       IRQ_LEVEL,
  input wire logic       IDLE_MODE_N
);
  // ------------------------------
  // shadow of the trigger register
  // ------------------------------
  logic [7:0] trig_q;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_q <= 8'hFF;
    end else if (CLK_EN && SFR_WE && SFR_ADDR == 8'hEA) begin
      trig_q <= SFR_WDATA;
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  // ------------------------------
  // assertions
  // ------------------------------
  a_ack_drops_req:
    assert property (IRQ_ACK && IRQ_REQ && CLK_EN |=> !IRQ_REQ)
    else $error("request stayed up after acknowledge");
  a_vector_legal:
    assert property (IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR <= 8'h7B
      && IRQ_VECTOR != 8'h3B)
    else $error("vector outside the fixed table");
  a_idle_entry:
    assert property ($fell(IDLE_MODE_N) |-> $past(INSTR_DONE) || $past(INSTR_DONE, 2))
    else $error("idle entered without instruction end");
  a_rdata_holds:
    assert property (!(SFR_RE && CLK_EN) |=> $stable(SFR_RDATA))
    else $error("read data moved without a read");
  a_high_no_nest:
    assert property (IRQ_ACK && IRQ_REQ && IRQ_LEVEL && CLK_EN
      |=> (!IRQ_REQ until IRQ_RETURN))
    else $error("request during high routine");
  a_low_only_high:
    assert property (IRQ_ACK && IRQ_REQ && !IRQ_LEVEL && CLK_EN
      |=> ((!IRQ_REQ || IRQ_LEVEL) until IRQ_RETURN))
    else $error("low request nested in low routine");
  a_unmapped_zero:
    assert property (SFR_RE && CLK_EN && SFR_ADDR == 8'h80 |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_trig_readback:
    assert property (SFR_RE && CLK_EN && SFR_ADDR == 8'hEA |=> SFR_RDATA == $past(trig_q))
    else $error("trigger register read mismatch");
  c_high_take: cover property (IRQ_ACK && IRQ_REQ && IRQ_LEVEL);
  c_low_take: cover property (IRQ_ACK && IRQ_REQ && !IRQ_LEVEL);
  c_idle_fall: cover property ($fell(IDLE_MODE_N));
endmodule
bind mcu_interrupt_controller intc_checker i_intc_checker (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
  .INSTR_DONE(INSTR_DONE), .IRQ_ACK(IRQ_ACK), .IRQ_RETURN(IRQ_RETURN),
  .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL),
  .IDLE_MODE_N(IDLE_MODE_N)
);
`default_nettype wire

// ---- verification/core_model.sv ----
// processor core stand-in that takes interrupt vectors
`default_nettype none
module core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       take,
  input  wire logic [3:0] delay,
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  output logic            irq_ack,
  output logic      [7:0] vec_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // ack held until the edge that takes it, vector latched at that edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      wait_q  <= 4'h0;
      vec_q   <= 8'h00;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      vec_q   <= irq_vector;
    end else if (!irq_req || !take) begin
      wait_q <= 4'h0;
    end else if (wait_q >= delay) begin
      irq_ack <= 1'b1;
      wait_q  <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_mcu_interrupt_controller.sv ----
// self-checking bench for the interrupt controller
`default_nettype none
module test_mcu_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic       pa = 1'b1;
  logic       pb = 1'b1;
  // extended lines 2..9 in bits 0..7, resting inactive
  logic [7:0] xl = 8'hAA;
  logic       ta = 1'b0;
  logic       tc = 1'b0;
  logic       srx = 1'b0;
  logic       lb = 1'b0;
  logic       idone = 1'b0;
  logic       ret_s = 1'b0;
  logic       take = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [7:0] rdata;
  logic [7:0] vec;
  logic [7:0] vq;
  logic       ack;
  logic       req;
  logic       lvl;
  logic       idlen;
  int         n_fail = 0;
  int         comparisons = 0;
  mcu_interrupt_controller i_mcu_interrupt_controller (
    .CORE_CLK(clk), .RSTN(rstn), .CLK_EN(ce), .SFR_ADDR(addr), .SFR_WDATA(wd),
    .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata), .EXT_REQUEST_PIN_A(pa),
    .EXT_REQUEST_PIN_B(pb), .SPI_REQUEST_LINE(xl[0]), .TWOWIRE_REQUEST_LINE(xl[1]),
    .USB_REQUEST_LINE(xl[2]), .RADIO_REQUEST_LINE(xl[3]), .SPARE_REQUEST_LINE(xl[4]),
    .PWM_REQUEST_LINE(xl[5]), .ADC_REQUEST_LINE(xl[6]), .CIPHER_REQUEST_LINE(xl[7]),
    .TIMER_A_OVERFLOW(ta), .TIMER_B_OVERFLOW(1'b0), .TIMER_C_OVERFLOW(tc),
    .TIMER_C_EXTERNAL(1'b0), .SERIAL_TRANSMIT_DONE(1'b0), .SERIAL_RECEIVE_DONE(srx),
    .LOW_BATTERY(lb), .INSTR_DONE(idone), .IRQ_ACK(ack), .IRQ_RETURN(ret_s),
    .IRQ_REQ(req), .IRQ_VECTOR(vec), .IRQ_LEVEL(lvl), .IDLE_MODE_N(idlen)
  );
  core_model i_core_model (
    .clk(clk), .rst_n(rstn), .take(take), .delay(dly), .irq_req(req),
    .irq_vector(vec), .irq_ack(ack), .vec_q(vq)
  );
  always #10 clk = ~clk;
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk("register", rdata, exp);
  endtask
  task automatic svc(input logic [7:0] exp);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 80);
    if (ack !== 1'b1) begin
      chk("ack wait", 8'h00, 8'h01);
      conclude();
    end
    #1;
    chk("vector", vq, exp);
  endtask
  task automatic ret();
    @(posedge clk) ret_s <= 1'b1;
    @(posedge clk) ret_s <= 1'b0;
  endtask
  task automatic no_req();
    cyc(4);
    #1;
    chk("request", {7'h00, req}, 8'h00);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic reset_values();
    rd(8'hEA, 8'hFF);
    rd(8'hE8, 8'hF0);
    rd(8'hA9, 8'h80);
    rd(8'h91, 8'h08);
    rd(8'h80, 8'h00);
    wr(8'hEA, 8'h55);
    rd(8'hEA, 8'h55);
    wr(8'hEA, 8'h00);
  endtask
  task automatic soft_set();
    wr(8'hA8, 8'h82);
    @(posedge clk) ta <= 1'b1;
    @(posedge clk) ta <= 1'b0;
    svc(8'h0B);
    rd(8'h88, 8'h00);
    ret();
    wr(8'h91, 8'h80);
    svc(8'h7B);
    rd(8'h91, 8'h80);
    wr(8'h91, 8'h00);
    ret();
  endtask
  task automatic pin_trigger();
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h81);
    @(posedge clk) pa <= 1'b0;
    svc(8'h03);
    ret();
    no_req();
    rd(8'h88, 8'h01);
    wr(8'h88, 8'h00);
    svc(8'h03);
    rd(8'h88, 8'h02);
    @(posedge clk) pa <= 1'b1;
    wr(8'h88, 8'h00);
    ret();
    no_req();
  endtask
  task automatic nesting();
    take <= 1'b0;
    dly <= 4'h3;
    wr(8'hA8, 8'hB4);
    wr(8'hA9, 8'h84);
    // timer C arrives first although its index is higher
    @(posedge clk) tc <= 1'b1;
    @(posedge clk) tc <= 1'b0;
    cyc(3);
    @(posedge clk) srx <= 1'b1;
    @(posedge clk) srx <= 1'b0;
    cyc(3);
    #1;
    chk("vector", vec, 8'h2B);
    chk("level", {7'h00, lvl}, 8'h00);
    take <= 1'b1;
    svc(8'h2B);
    no_req();
    @(posedge clk) pb <= 1'b0;
    svc(8'h13);
    chk("level", {7'h00, lvl}, 8'h01);
    @(posedge clk) pb <= 1'b1;
    wr(8'h88, 8'h00);
    ret();
    wr(8'hC8, 8'h00);
    ret();
    svc(8'h23);
    wr(8'h98, 8'h00);
    ret();
    dly <= 4'h0;
  endtask
  task automatic ext_lines();
    wr(8'hA8, 8'h00);
    wr(8'hE8, 8'hFF);
    @(posedge clk) xl <= 8'h55;
    cyc(3);
    @(posedge clk) xl <= 8'hAA;
    rd(8'h91, 8'hFF);
    chk("request", {7'h00, req}, 8'h00);
    wr(8'h91, 8'h00);
    rd(8'h91, 8'h00);
    // spi line held active in edge mode flags only once
    wr(8'hEA, 8'h01);
    @(posedge clk) xl <= 8'hAB;
    cyc(3);
    rd(8'h91, 8'h01);
    wr(8'h91, 8'h00);
    rd(8'h91, 8'h00);
    // a level event while frozen leaves no trace
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) xl <= 8'hAE;
    @(posedge clk) xl <= 8'hAA;
    @(posedge clk) ce <= 1'b1;
    rd(8'h91, 8'h00);
  endtask
  task automatic idle_wake();
    wr(8'h93, 8'h20);
    wr(8'h87, 8'h01);
    cyc(3);
    #1;
    chk("idle", {7'h00, idlen}, 8'h01);
    @(posedge clk) idone <= 1'b1;
    @(posedge clk) idone <= 1'b0;
    cyc(1);
    #1;
    chk("idle", {7'h00, idlen}, 8'h00);
    @(posedge clk) lb <= 1'b1;
    @(posedge clk) lb <= 1'b0;
    svc(8'h33);
    chk("idle", {7'h00, idlen}, 8'h01);
    rd(8'h87, 8'h00);
    wr(8'h93, 8'h20);
    ret();
    no_req();
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    reset_values();
    take <= 1'b1;
    soft_set();
    pin_trigger();
    nesting();
    ext_lines();
    idle_wake();
    conclude();
  end
endmodule
`default_nettype wire
